// >>> src/wdt_pkg.sv
// Shared constants, register map and state type for the digital watchdog.
package wdt_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned BE_W          = 4;
  localparam logic [7:0]  WDOG_OFFSET   = 8'hd8;
  localparam logic [7:0]  STATUS_OFFSET = 8'hdc;

  // ----------------------------------------------------------------------
  // Watchdog counter/control register layout
  // ----------------------------------------------------------------------
  localparam int unsigned REG_W      = 8;
  localparam int unsigned CTRL_BIT   = 0;
  localparam int unsigned SR_BIT     = 1;
  localparam int unsigned PERIOD_HI  = 7;
  localparam int unsigned PERIOD_W   = 6;
  localparam int unsigned CNT_W      = 7;
  localparam logic [7:0]  WDOG_RESET = 8'hfe;
  localparam logic [6:0]  CNT_RESET  = 7'h7f;
  localparam logic [6:0]  CNT_EXPIRE = 7'h40;
  localparam logic [6:0]  CNT_ONE    = 7'h01;

  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int unsigned ST_ACTIVE_BIT = 0;
  localparam int unsigned ST_HWOPT_BIT  = 1;
  localparam int unsigned ST_HALT_BIT   = 2;

  // ----------------------------------------------------------------------
  // Timing, in oscillator clock cycles
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_DIV           = 12;
  localparam int unsigned STEP_DIV          = 256;
  localparam int unsigned STEP_CYCLES       = CLK_DIV * STEP_DIV;
  localparam int unsigned MIN_PERIOD_CYCLES = 3072;
  localparam int unsigned MAX_PERIOD_CYCLES = 196608;
  localparam int unsigned STAB_CYCLES       = 2048;

  // ----------------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_RST_HOLD} wdt_state_t;

endpackage

// >>> src/wdt_tick_if.sv
// Carrier between the watchdog core and its period prescaler.
`timescale 1ns/1ps
interface wdt_tick_if;
  logic run;
  logic restart;
  logic step;

  modport ctl (output run, output restart, input step);
  modport pre (input run, input restart, output step);
endinterface

// >>> src/wdt_prescaler.sv
// Prescaler that turns the oscillator clock into watchdog period steps.
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int unsigned CLK_DIV  = wdt_pkg::CLK_DIV,
  parameter int unsigned STEP_DIV = wdt_pkg::STEP_DIV
) (
  input  wire logic clk,
  input  wire logic nrst,
  wdt_tick_if.pre   bus
);
  import wdt_pkg::*;

  localparam int unsigned DIV_W  = $clog2(CLK_DIV);
  localparam int unsigned STEP_W = $clog2(STEP_DIV);

  logic [DIV_W-1:0]  div_q;
  logic [STEP_W-1:0] sub_q;
  logic              step_q;
  logic              div_last;
  logic              sub_last;

  assign div_last = (div_q == DIV_W'(CLK_DIV - 1));
  assign sub_last = (sub_q == STEP_W'(STEP_DIV - 1));
  assign bus.step = step_q;

  // ----------------------------------------------------------------------
  // Divide by twelve, then by the sub-step count
  // ----------------------------------------------------------------------
  // A halted oscillator freezes both stages, so counting resumes exactly.
  always_ff @(posedge clk)
  begin
    if (!nrst || bus.restart)
    begin
      div_q <= '0;
    end
    else if (bus.run)
    begin
      div_q <= div_last ? '0 : div_q + DIV_W'(1); // [R14]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || bus.restart)
    begin
      sub_q <= '0;
    end
    else if (bus.run && div_last)
    begin
      sub_q <= sub_last ? '0 : sub_q + STEP_W'(1); // [R18]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || bus.restart)
    begin
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= bus.run && div_last && sub_last; // [R18]
    end
  end

endmodule

// >>> src/digital_watchdog_timer.sv
// Digital watchdog: reloadable downcounter, reset generator and stop control.
`timescale 1ns/1ps
//
// Overview of operation
// [R1] Active counter reaching zero resets the chip.
// [R2] Software reloads the period before it expires.
// [R3] Software option: inactive until control bit written.
// [R4] Once active, only a reset deactivates it.
// [R5] Hardware option: always counting, never stoppable.
// [R6] Hardware option: stop behaves as wait.
// [R7] Inactive watchdog lets stop halt the oscillator.
// [R8] Wake from stop resumes counting from held state.
// [R9] Register resets to fe, longest period.
// [R10] Writing software-reset bit low resets immediately.
// [R11] Period bits map to counter in reverse.
// [R12] Counter bit six falling triggers the reset.
// [R13] Sixty-four periods from 3072 to 196608 cycles.
// [R14] Watchdog clock is the clock divided by twelve.
// [R15] Hardware option forces the control bit high.
// [R16] Inactive counter is a free 7-bit timer.
// [R17] Watchdog reset includes the stabilisation delay.
// [R18] Each period step lasts 3072 clock cycles.
module digital_watchdog_timer #(
  parameter int unsigned STAB_LEN = wdt_pkg::STAB_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        hw_option_pin,
  input  wire logic                        cpu_stop_req,
  input  wire logic                        wake_irq,
  input  wire logic [wdt_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [wdt_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [wdt_pkg::BE_W-1:0]    avs_byteenable,
  output      logic [wdt_pkg::DATA_W-1:0]  avs_readdata,
  output      logic                        avs_waitrequest,
  output      logic                        osc_halt,
  output      logic                        chip_rst_req
);
  import wdt_pkg::*;

  localparam int unsigned STAB_W = $clog2(STAB_LEN + 1);
  localparam int unsigned GAP_W  = $clog2(STEP_CYCLES + 1);

  logic                hw_sync1_q;
  logic                hw_sync2_q;
  logic                hw_opt_q;
  logic                c_q;
  logic [CNT_W-1:0]    cnt_q;
  wdt_state_t          state_q;
  wdt_state_t          state_d;
  logic [STAB_W-1:0]   stab_q;
  logic                waitreq_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                osc_halt_q;
  logic                chip_rst_q;
  logic                active;
  logic                wr_ack;
  logic                rd_ack;
  logic                wr_wd;
  logic                sw_rst;
  logic                expire;
  logic                rst_evt;
  logic                stab_done;
  logic [CNT_W-1:0]    wd_cnt;
  logic [REG_W-1:0]    wd_view;
  logic [DATA_W-1:0]   rd_mux;

  wdt_tick_if tick_bus ();

  wdt_prescaler #(
    .CLK_DIV  (CLK_DIV),
    .STEP_DIV (STEP_DIV)
  ) u_prescaler (
    .clk  (clk),
    .nrst (nrst),
    .bus  (tick_bus.pre)
  );

  // ----------------------------------------------------------------------
  // Activation option strap
  // ----------------------------------------------------------------------
  // The strap is caught while reset is held, so it must settle two clocks
  // before release; a later change of the pin has no effect.
  always_ff @(posedge clk)
  begin
    hw_sync1_q <= hw_option_pin;
    hw_sync2_q <= hw_sync1_q;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hw_opt_q <= hw_sync2_q;
    end
  end

  assign active = hw_opt_q || c_q; // [R5] [R15]

  // ----------------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------------
  assign wr_ack  = avs_write && !waitreq_q;
  assign rd_ack  = avs_read && !waitreq_q;
  assign wr_wd   = wr_ack && (avs_address == WDOG_OFFSET) && avs_byteenable[0]
                   && (state_q != ST_RST_HOLD);
  assign sw_rst  = wr_wd && !avs_writedata[SR_BIT]; // [R10]
  assign expire  = active && tick_bus.step && (state_q == ST_RUN)
                   && (cnt_q == CNT_EXPIRE) && !wr_wd; // [R1] [R12] [R13]
  assign rst_evt = sw_rst || expire;

  // Period bits are stored reversed against the physical counter.
  for (genvar i = 0; i < PERIOD_W; i++)
  begin : g_period_map
    assign wd_cnt[i]            = avs_writedata[PERIOD_HI - i]; // [R11]
    assign wd_view[PERIOD_HI - i] = cnt_q[i]; // [R11]
  end
  assign wd_cnt[CNT_W-1]   = avs_writedata[SR_BIT];
  assign wd_view[SR_BIT]   = cnt_q[CNT_W-1];
  assign wd_view[CTRL_BIT] = active; // [R15]

  always_comb
  begin
    rd_mux = '0;
    if (avs_address == WDOG_OFFSET)
    begin
      rd_mux[REG_W-1:0] = wd_view;
    end
    else if (avs_address == STATUS_OFFSET)
    begin
      rd_mux[ST_ACTIVE_BIT] = active;
      rd_mux[ST_HWOPT_BIT]  = hw_opt_q;
      rd_mux[ST_HALT_BIT]   = osc_halt_q;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon slave handshake
  // ----------------------------------------------------------------------
  // Every access costs one wait cycle, which keeps read data registered.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      waitreq_q <= 1'b1;
    end
    else
    begin
      waitreq_q <= !((avs_read || avs_write) && waitreq_q);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
    end
    else if (avs_read && waitreq_q)
    begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Control bit and downcounter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || rst_evt || state_q == ST_RST_HOLD)
    begin
      c_q <= WDOG_RESET[CTRL_BIT]; // [R9]
    end
    else if (wr_wd && avs_writedata[CTRL_BIT])
    begin
      c_q <= 1'b1; // [R3] [R4]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || rst_evt || state_q == ST_RST_HOLD)
    begin
      cnt_q <= CNT_RESET; // [R9]
    end
    else if (wr_wd)
    begin
      cnt_q <= wd_cnt; // [R11]
    end
    else if (tick_bus.step)
    begin
      cnt_q <= cnt_q - CNT_ONE; // [R1] [R16]
    end
  end

  // ----------------------------------------------------------------------
  // Run, stop and reset-hold sequencing
  // ----------------------------------------------------------------------
  assign stab_done = (stab_q == STAB_W'(STAB_LEN - 1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
      begin
        if (rst_evt)
        begin
          state_d = ST_RST_HOLD; // [R1] [R10]
        end
        else if (cpu_stop_req && !active)
        begin
          state_d = ST_STOPPED; // [R7] [R6]
        end
      end
      ST_STOPPED:
      begin
        // The bus stays live while the oscillator is halted, so a software reset must still win.
        if (rst_evt)
        begin
          state_d = ST_RST_HOLD; // [R10]
        end
        else if (wake_irq)
        begin
          state_d = ST_RUN; // [R8]
        end
      end
      ST_RST_HOLD:
      begin
        if (stab_done)
        begin
          state_d = ST_RUN; // [R17]
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || state_q != ST_RST_HOLD)
    begin
      stab_q <= '0;
    end
    else
    begin
      stab_q <= stab_q + STAB_W'(1); // [R17]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      osc_halt_q <= 1'b0;
      chip_rst_q <= 1'b0;
    end
    else
    begin
      osc_halt_q <= (state_d == ST_STOPPED); // [R7]
      chip_rst_q <= (state_d == ST_RST_HOLD); // [R17]
    end
  end

  // Counting freezes with the oscillator and during reset hold; a reload restarts the step.
  assign tick_bus.run     = (state_q == ST_RUN); // [R6] [R8]
  assign tick_bus.restart = wr_wd || (state_q == ST_RST_HOLD); // [R2] [R17]

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign osc_halt        = osc_halt_q;
  assign chip_rst_req    = chip_rst_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [GAP_W-1:0] gap_q;

  always_ff @(posedge clk)
  begin
    if (!nrst || tick_bus.restart)
    begin
      gap_q <= '0;
    end
    else if (tick_bus.run)
    begin
      gap_q <= tick_bus.step ? GAP_W'(1) : gap_q + GAP_W'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_sw_reset_write;
    wr_wd ##0 !avs_writedata[SR_BIT];
  endsequence

  sequence s_hold_entered;
    chip_rst_q ##0 !osc_halt_q;
  endsequence

  property p_expire_resets;
    active && tick_bus.step && state_q == ST_RUN && !wr_wd && cnt_q == CNT_EXPIRE
      |=> s_hold_entered ##1 chip_rst_q;
  endproperty
  a_expire_resets: assert property (p_expire_resets) // [R1] [R12]
    else $error("Watchdog expiry did not raise the chip reset.");

  property p_soft_activation;
    $rose(c_q) |-> $past(wr_wd) && $past(avs_writedata[CTRL_BIT]);
  endproperty
  a_soft_activation: assert property (p_soft_activation) // [R3]
    else $error("Control bit rose without a software write.");

  property p_no_deactivate;
    active && !chip_rst_q && !rst_evt |=> active;
  endproperty
  a_no_deactivate: assert property (p_no_deactivate) // [R4]
    else $error("Watchdog was deactivated without a reset.");

  property p_hw_never_halts;
    hw_opt_q |-> !osc_halt_q && wd_view[CTRL_BIT];
  endproperty
  a_hw_never_halts: assert property (p_hw_never_halts) // [R5] [R15]
    else $error("Hardware-activated watchdog stopped or read inactive.");

  property p_stop_as_wait;
    active && state_q == ST_RUN && cpu_stop_req && !rst_evt
      |=> !osc_halt_q ##0 tick_bus.run;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) // [R6]
    else $error("Stop halted the oscillator while the watchdog was active.");

  property p_stop_allowed;
    !active && state_q == ST_RUN && cpu_stop_req && !rst_evt |=> osc_halt_q [*2];
  endproperty
  a_stop_allowed: assert property (p_stop_allowed) // [R7]
    else $error("Inactive watchdog did not allow the oscillator to halt.");

  property p_wake_resume;
    osc_halt_q && wake_irq && !rst_evt
      |=> !osc_halt_q ##0 cnt_q == $past(cnt_q) ##1 tick_bus.run;
  endproperty
  a_wake_resume: assert property (p_wake_resume) // [R8]
    else $error("Counting did not resume from the held count after wake.");

  property p_reset_value;
    $rose(nrst) |-> cnt_q == CNT_RESET && !c_q && state_q == ST_RUN;
  endproperty
  a_reset_value: assert property (p_reset_value) // [R9]
    else $error("Watchdog register did not leave reset at its reset value.");

  property p_soft_reset;
    s_sw_reset_write |=> s_hold_entered;
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R10]
    else $error("Writing the software-reset bit low gave no reset.");

  property p_reverse_read;
    avs_read && waitreq_q && avs_address == WDOG_OFFSET
      |=> rdata_q[PERIOD_HI] == $past(cnt_q[0]) && rdata_q[SR_BIT] == $past(cnt_q[CNT_W-1]);
  endproperty
  a_reverse_read: assert property (p_reverse_read) // [R11]
    else $error("Period bits did not read back in reversed order.");

  property p_step_spacing;
    tick_bus.step |-> gap_q == GAP_W'(STEP_CYCLES);
  endproperty
  a_step_spacing: assert property (p_step_spacing) // [R13] [R14] [R18]
    else $error("Period step did not last the full step count.");

  property p_timer_wrap;
    !active && tick_bus.step && !wr_wd && cnt_q == '0 |=> cnt_q == CNT_RESET && !chip_rst_q;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) // [R16]
    else $error("Inactive counter did not wrap as a plain timer.");

  property p_hold_length;
    $fell(chip_rst_q) |-> $past(stab_q) == STAB_W'(STAB_LEN - 1);
  endproperty
  a_hold_length: assert property (p_hold_length) // [R17]
    else $error("Chip reset was not held for the stabilisation delay.");

endmodule

// >>> sim/tb_digital_watchdog_timer.sv
// Self-checking testbench for the digital watchdog timer.
`timescale 1ns/1ps
module tb_digital_watchdog_timer;
  import wdt_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int STAB = 8;
  localparam int STEP = 3072;
  logic              clk;
  logic              nrst;
  logic              hw_option_pin;
  logic              cpu_stop_req;
  logic              wake_irq;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0]   avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              osc_halt;
  logic              chip_rst_req;
  logic [DATA_W-1:0] exp_q[$];
  int                errors;
  int                comparisons;
  int                p;
  logic [5:0]        t;

  digital_watchdog_timer #(.STAB_LEN(STAB)) DUT (
    .clk(clk), .nrst(nrst), .hw_option_pin(hw_option_pin),
    .cpu_stop_req(cpu_stop_req), .wake_irq(wake_irq), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_halt(osc_halt), .chip_rst_req(chip_rst_req));

  // ----------------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_span(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Read data are judged where they appear, against the oldest noted value.
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk_data("readdata_unexpected", 32'h0, 32'hffffffff);
      else
        chk_data("readdata", exp_q.pop_front(), avs_readdata);
    end

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int w;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= we;
    avs_read       <= ~we;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= 4'hf;
    w = 0;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (avs_waitrequest !== 1'b0 && w < 50);
    if (w >= 50)
      chk_bit("waitrequest", 1'b0, avs_waitrequest);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h0);
  endtask

  task automatic pulse(input logic stop);
    @(posedge clk);
    if (stop)
      cpu_stop_req <= 1'b1;
    else
      wake_irq <= 1'b1;
    @(posedge clk);
    cpu_stop_req <= 1'b0;
    wake_irq     <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic do_reset(input logic hw);
    nrst          <= 1'b0;
    hw_option_pin <= hw;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  // Measures the delay from now to the reset event, then its length.
  task automatic wait_rst(input int lo, input int hi);
    int k;
    int n;
    k = 0;
    n = 0;
    while (chip_rst_req !== 1'b1 && k <= hi)
    begin
      @(posedge clk);
      k++;
    end
    chk_span("reset_delay", lo, hi, k);
    while (chip_rst_req === 1'b1 && n <= STAB + 2)
    begin
      @(posedge clk);
      n++;
    end
    chk_span("reset_length", STAB, STAB, n);
  endtask

  // Register bits 7..2 carry counter bits 0..5 in reverse.
  function automatic logic [7:0] enc(input logic [5:0] v, input logic sr, input logic c);
    logic [7:0] r;
    r = {6'h0, sr, c};
    for (int i = 0; i < 6; i++)
      r[7-i] = v[i];
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The tests need about 30000 cycles; twice that means a hang.
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("mismatch run_length expected finish seen timeout");
    results();
  end

  initial
  begin
    {nrst, hw_option_pin, cpu_stop_req, wake_irq, avs_read, avs_write} = '0;
    avs_address    = '0;
    avs_writedata  = '0;
    avs_byteenable = '0;
    errors         = 0;
    comparisons    = 0;
    void'($urandom(18940));
    do_reset(1'b0);
    rd(WDOG_OFFSET, 32'hfe);
    rd(STATUS_OFFSET, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset_values done");
    bus(1'b1, WDOG_OFFSET, enc(6'h01, 1'b1, 1'b0));
    repeat (STEP + 8) @(posedge clk);
    rd(WDOG_OFFSET, 32'h02);
    pulse(1'b1);
    chk_bit("osc_halt", 1'b1, osc_halt);
    repeat (STEP + 8) @(posedge clk);
    rd(WDOG_OFFSET, 32'h02);
    pulse(1'b0);
    chk_bit("osc_halt", 1'b0, osc_halt);
    repeat (STEP + 8) @(posedge clk);
    rd(WDOG_OFFSET, 32'hfc);
    chk_bit("chip_rst_req", 1'b0, chip_rst_req);
    $display("test inactive_timer done");
    t = 6'($urandom_range(3, 0));
    p = (int'(t) + 1) * STEP;
    bus(1'b1, WDOG_OFFSET, enc(t, 1'b1, 1'b1));
    rd(STATUS_OFFSET, 32'h1);
    pulse(1'b1);
    chk_bit("osc_halt", 1'b0, osc_halt);
    bus(1'b1, WDOG_OFFSET, enc(t, 1'b1, 1'b0));
    rd(STATUS_OFFSET, 32'h1);
    wait_rst(p - 2, p + 4);
    rd(STATUS_OFFSET, 32'h0);
    rd(WDOG_OFFSET, 32'hfe);
    $display("test active_timeout done");
    bus(1'b1, WDOG_OFFSET, enc(6'h00, 1'b1, 1'b1));
    for (int i = 0; i < 3; i++)
    begin
      repeat (STEP - 200) @(posedge clk);
      chk_bit("chip_rst_req", 1'b0, chip_rst_req);
      bus(1'b1, WDOG_OFFSET, enc(6'h00, 1'b1, 1'b1));
    end
    wait_rst(STEP - 2, STEP + 4);
    $display("test reload done");
    bus(1'b1, WDOG_OFFSET, enc(6'h3f, 1'b0, 1'b0));
    wait_rst(0, 4);
    $display("test software_reset done");
    do_reset(1'b1);
    rd(WDOG_OFFSET, 32'hff);
    rd(STATUS_OFFSET, 32'h3);
    pulse(1'b1);
    chk_bit("osc_halt", 1'b0, osc_halt);
    bus(1'b1, WDOG_OFFSET, enc(6'h00, 1'b1, 1'b0));
    wait_rst(STEP - 2, STEP + 4);
    $display("test hardware_option done");
    results();
  end
endmodule
